//--- pkg/cpld_pkg.sv
// shared sizes, control-term roles and configuration encodings of the logic block
package cpld_pkg;

  localparam int NUM_INPUTS  = 36;
  localparam int NUM_MC      = 16;
  localparam int PAL_PER_MC  = 5;
  localparam int NUM_PAL     = NUM_MC * PAL_PER_MC;
  localparam int PLA_TERMS   = 32;
  localparam int NUM_CT      = 6;
  localparam int NUM_GCLK    = 4;
  localparam int NUM_FB      = 2 * NUM_MC;
  localparam int NUM_CLK_SRC = 6;
  localparam int MC_IDX_W    = 4;

  // control-term roles inside one block
  localparam int CT_PRESET   = 0;
  localparam int CT_RESET    = 1;
  localparam int CT_CLK_A    = 2;
  localparam int CT_CLK_B    = 3;
  localparam int CT_OE_C     = 4;
  localparam int CT_OE_D     = 5;

  // global clock zero has no internal source; internal selection starts here
  localparam int GCLK_INT_LO = 1;
  localparam int GCLK_ZERO   = 0;

  typedef enum logic [1:0] {
    mode_comb,
    mode_d,
    mode_t
  } mc_mode_t;

  typedef enum logic [2:0] {
    src_gclk0,
    src_gclk1,
    src_gclk2,
    src_gclk3,
    src_ct2,
    src_ct3
  } clk_src_t;

  typedef enum logic [2:0] {
    oe_ct2,
    oe_ct3,
    oe_ct4,
    oe_ct5,
    oe_always_on,
    oe_always_off
  } oe_src_t;

endpackage

//--- src/sum_product_term.sv
// one programmable term: AND or OR over chosen true and complemented inputs
module sum_product_term #(
  parameter int WIDTH = 36
) (
  input  wire logic [WIDTH-1:0] signals,
  input  wire logic [WIDTH-1:0] true_mask,
  input  wire logic [WIDTH-1:0] comp_mask,
  input  wire logic             sum_mode,
  output logic                  term
);

  logic product_val;
  logic sum_val;

  // an empty product is true and an empty sum is false
  assign product_val = (&(~true_mask | signals)) & (&(~comp_mask | ~signals));
  assign sum_val     = (|(true_mask & signals)) | (|(comp_mask & ~signals));
  assign term        = sum_mode ? sum_val : product_val;

endmodule

//--- src/macrocell_cell.sv
// one macrocell storage element: combinational, d or toggle, with preset and reset
module macrocell_cell (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  cpld_pkg::mc_mode_t     mode,
  input  wire logic              clk_en,
  input  wire logic              d_in,
  input  wire logic              preset,
  input  wire logic              reset,
  input  wire logic              pr_enable,
  output logic                   q
);
  import cpld_pkg::*;

  logic q_reg;

  // reset beats preset; both act on the next fabric edge whatever clock is chosen
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_reg <= 1'h0;
    end else if (pr_enable && reset) begin
      q_reg <= 1'h0;
    end else if (pr_enable && preset) begin
      q_reg <= 1'h1;
    end else begin
      case (mode)
        mode_comb: begin
          q_reg <= d_in;
        end
        mode_d: begin
          if (clk_en) begin
            q_reg <= d_in;
          end
        end
        mode_t: begin
          if (clk_en && d_in) begin
            q_reg <= ~q_reg;
          end
        end
        default: begin
          q_reg <= q_reg;
        end
      endcase
    end
  end

  assign q = q_reg;

  power_clear_a: assert property (@(posedge clock) !rstn |=> !q)
    else $error("macrocell not cleared by reset");

  reset_wins_a: assert property (@(posedge clock) disable iff (!rstn)
    pr_enable && reset |=> !q)
    else $error("reset term did not clear the macrocell");

  preset_sets_a: assert property (@(posedge clock) disable iff (!rstn)
    pr_enable && preset && !reset |=> q)
    else $error("preset term did not set the macrocell");

  pr_ignored_a: assert property (@(posedge clock) disable iff (!rstn)
    !pr_enable && mode == mode_d && !clk_en |=> $stable(q))
    else $error("disabled preset or reset changed the macrocell");

  d_capture_a: assert property (@(posedge clock) disable iff (!rstn)
    mode == mode_d && clk_en && !(pr_enable && (preset || reset)) |=> q == $past(d_in))
    else $error("d element missed its data on a clock edge");

  t_toggle_a: assert property (@(posedge clock) disable iff (!rstn)
    mode == mode_t && clk_en && d_in && !(pr_enable && (preset || reset))
    |=> q != $past(q))
    else $error("toggle element did not toggle");

  edge_only_a: assert property (@(posedge clock) disable iff (!rstn)
    mode != mode_comb && !clk_en && !(pr_enable && (preset || reset)) |=> $stable(q))
    else $error("storage element changed without its clock edge");

  comb_follow_a: assert property (@(posedge clock) disable iff (!rstn)
    mode == mode_comb && !(pr_enable && (preset || reset)) |=> q == $past(d_in))
    else $error("combinational path does not follow its logic");

endmodule

//--- src/cpld_logic_block.sv
// one configurable logic block: term arrays, control terms, clocking and 16 macrocells
module cpld_logic_block (
  input  wire logic                                                    clock,
  input  wire logic                                                    rstn,
  input  wire logic                                                    global_clock_zero,
  input  wire logic                                                    global_clock_one,
  input  wire logic                                                    global_clock_two,
  input  wire logic                                                    global_clock_three,
  input  wire logic                                                    global_output_float_n,
  input  wire logic                                                    float_enable,
  input  wire logic [cpld_pkg::NUM_INPUTS-1:0]                         global_interconnect_array,
  output logic      [cpld_pkg::NUM_FB-1:0]                             feedback_out,
  input  wire logic [cpld_pkg::NUM_MC-1:0]                             pin_in,
  output logic      [cpld_pkg::NUM_MC-1:0]                             pin_out,
  output logic      [cpld_pkg::NUM_MC-1:0]                             pin_oe_n,
  input  wire logic [cpld_pkg::NUM_PAL-1:0][cpld_pkg::NUM_INPUTS-1:0]  pal_true_mask,
  input  wire logic [cpld_pkg::NUM_PAL-1:0][cpld_pkg::NUM_INPUTS-1:0]  pal_comp_mask,
  input  wire logic [cpld_pkg::PLA_TERMS-1:0][cpld_pkg::NUM_INPUTS-1:0] pla_true_mask,
  input  wire logic [cpld_pkg::PLA_TERMS-1:0][cpld_pkg::NUM_INPUTS-1:0] pla_comp_mask,
  input  wire logic [cpld_pkg::NUM_MC-1:0][cpld_pkg::PLA_TERMS-1:0]    pla_or_mask,
  input  wire logic [cpld_pkg::NUM_CT-1:0][cpld_pkg::NUM_INPUTS-1:0]   ct_true_mask,
  input  wire logic [cpld_pkg::NUM_CT-1:0][cpld_pkg::NUM_INPUTS-1:0]   ct_comp_mask,
  input  wire logic [cpld_pkg::NUM_CT-1:0]                             ct_sum_mode,
  input  cpld_pkg::mc_mode_t                                           mc_mode [cpld_pkg::NUM_MC],
  input  cpld_pkg::clk_src_t                                           mc_clk_src [cpld_pkg::NUM_MC],
  input  cpld_pkg::oe_src_t                                            mc_oe_src [cpld_pkg::NUM_MC],
  input  wire logic [cpld_pkg::NUM_MC-1:0]                             mc_pr_enable,
  input  wire logic [cpld_pkg::NUM_GCLK-1:0]                           gclk_falling,
  input  wire logic [cpld_pkg::NUM_GCLK-1:cpld_pkg::GCLK_INT_LO]       gclk_internal,
  input  wire logic [cpld_pkg::NUM_GCLK-1:cpld_pkg::GCLK_INT_LO][cpld_pkg::MC_IDX_W-1:0] gclk_eq_mc
);
  import cpld_pkg::*;

  logic [NUM_PAL-1:0]     pal_term;
  logic [PLA_TERMS-1:0]   pla_term;
  logic [NUM_CT-1:0]      ctrl_term;
  logic [NUM_MC-1:0]      mc_d;
  logic [NUM_MC-1:0]      mc_logic;
  logic [NUM_MC-1:0]      mc_clk_en;

  logic [NUM_GCLK-1:0]    gclk_s1_reg;
  logic [NUM_GCLK-1:0]    gclk_s2_reg;
  logic [NUM_GCLK-1:0]    gclk_prev_reg;
  logic [NUM_GCLK-1:0]    gclk_level;
  logic [NUM_GCLK-1:0]    gclk_edge;
  logic [1:0]             ct_clk_prev_reg;
  logic [1:0]             ct_clk_rise;
  logic [NUM_CLK_SRC-1:0] src_en;

  logic                   float_s1_reg;
  logic                   float_s2_reg;
  logic                   float_active;
  logic [NUM_MC-1:0]      pin_s1_reg;
  logic [NUM_MC-1:0]      pin_s2_reg;
  logic [NUM_MC-1:0]      oe_on;
  logic [NUM_MC-1:0]      pin_oe_n_reg;

  // product terms of the fixed-or array and of the shared pool
  for (genvar p = 0; p < NUM_PAL; p++) begin : g_pal
    sum_product_term #(.WIDTH(NUM_INPUTS)) u_pal (
      .signals   (global_interconnect_array),
      .true_mask (pal_true_mask[p]),
      .comp_mask (pal_comp_mask[p]),
      .sum_mode  (1'h0),
      .term      (pal_term[p])
    );
  end

  for (genvar p = 0; p < PLA_TERMS; p++) begin : g_pla
    sum_product_term #(.WIDTH(NUM_INPUTS)) u_pla (
      .signals   (global_interconnect_array),
      .true_mask (pla_true_mask[p]),
      .comp_mask (pla_comp_mask[p]),
      .sum_mode  (1'h0),
      .term      (pla_term[p])
    );
  end

  for (genvar c = 0; c < NUM_CT; c++) begin : g_ct
    sum_product_term #(.WIDTH(NUM_INPUTS)) u_ct (
      .signals   (global_interconnect_array),
      .true_mask (ct_true_mask[c]),
      .comp_mask (ct_comp_mask[c]),
      .sum_mode  (ct_sum_mode[c]),
      .term      (ctrl_term[c])
    );
  end

  // each pool term may be or-ed into any number of macrocells at once
  for (genvar k = 0; k < NUM_MC; k++) begin : g_or
    assign mc_d[k] = (|pal_term[k*PAL_PER_MC +: PAL_PER_MC])
                   | (|(pla_term & pla_or_mask[k]));
  end

  // clock pins come from outside the fabric clock and are synchronised first
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gclk_s1_reg <= '0;
      gclk_s2_reg <= '0;
    end else begin
      gclk_s1_reg <= {global_clock_three, global_clock_two, global_clock_one,
                      global_clock_zero};
      gclk_s2_reg <= gclk_s1_reg;
    end
  end

  // clock zero has no internal option at all
  assign gclk_level[GCLK_ZERO] = gclk_s2_reg[GCLK_ZERO];
  for (genvar g = GCLK_INT_LO; g < NUM_GCLK; g++) begin : g_gsel
    assign gclk_level[g] = gclk_internal[g] ? mc_logic[gclk_eq_mc[g]]
                                            : gclk_s2_reg[g];
  end

  // a rising-edge clock that sits high at release gives one edge; keep clocks low in reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gclk_prev_reg <= '0;
    end else begin
      gclk_prev_reg <= gclk_level;
    end
  end

  assign gclk_edge = (gclk_falling & ~gclk_level & gclk_prev_reg)
                   | (~gclk_falling & gclk_level & ~gclk_prev_reg);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ct_clk_prev_reg <= '0;
    end else begin
      ct_clk_prev_reg <= {ctrl_term[CT_CLK_B], ctrl_term[CT_CLK_A]};
    end
  end

  assign ct_clk_rise = {ctrl_term[CT_CLK_B], ctrl_term[CT_CLK_A]} & ~ct_clk_prev_reg;
  assign src_en      = {ct_clk_rise, gclk_edge};

  for (genvar k = 0; k < NUM_MC; k++) begin : g_mc
    assign mc_clk_en[k] = src_en[mc_clk_src[k]];
    macrocell_cell u_mc (
      .clock     (clock),
      .rstn      (rstn),
      .mode      (mc_mode[k]),
      .clk_en    (mc_clk_en[k]),
      .d_in      (mc_d[k]),
      .preset    (ctrl_term[CT_PRESET]),
      .reset     (ctrl_term[CT_RESET]),
      .pr_enable (mc_pr_enable[k]),
      .q         (mc_logic[k])
    );
  end

  // global float pin and input pins pass two flops before use
  always_ff @(posedge clock) begin
    if (!rstn) begin
      float_s1_reg <= 1'h1;
      float_s2_reg <= 1'h1;
    end else begin
      float_s1_reg <= global_output_float_n;
      float_s2_reg <= float_s1_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign float_active = float_enable & ~float_s2_reg;

  always_comb begin
    for (int k = 0; k < NUM_MC; k++) begin
      case (mc_oe_src[k])
        oe_ct2:        oe_on[k] = ctrl_term[CT_CLK_A];
        oe_ct3:        oe_on[k] = ctrl_term[CT_CLK_B];
        oe_ct4:        oe_on[k] = ctrl_term[CT_OE_C];
        oe_ct5:        oe_on[k] = ctrl_term[CT_OE_D];
        oe_always_on:  oe_on[k] = 1'h1;
        oe_always_off: oe_on[k] = 1'h0;
        default:       oe_on[k] = 1'h0;
      endcase
    end
  end

  // outputs float during reset so nothing drives before the fabric is defined
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_oe_n_reg <= '1;
    end else if (float_active) begin
      pin_oe_n_reg <= '1;
    end else begin
      pin_oe_n_reg <= ~oe_on;
    end
  end

  assign pin_oe_n     = pin_oe_n_reg;
  assign pin_out      = mc_logic;
  assign feedback_out = {pin_s2_reg, mc_logic};

  gclk0_rise_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(global_clock_zero) && !gclk_falling[GCLK_ZERO] ##1 !gclk_falling[GCLK_ZERO]
    ##1 !gclk_falling[GCLK_ZERO] |-> src_en[GCLK_ZERO])
    else $error("rising pin edge of clock zero not seen");

  gclk0_fall_a: assert property (@(posedge clock) disable iff (!rstn)
    $fell(global_clock_zero) && gclk_falling[GCLK_ZERO] ##1 gclk_falling[GCLK_ZERO]
    ##1 gclk_falling[GCLK_ZERO] |-> src_en[GCLK_ZERO])
    else $error("falling pin edge of clock zero not seen");

  float_all_a: assert property (@(posedge clock) disable iff (!rstn)
    float_enable && !global_output_float_n ##1 float_enable ##1 float_enable
    |=> &pin_oe_n)
    else $error("outputs not floated by global float pin");

  pin_fb_a: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) && $past(rstn, 2) |-> feedback_out[NUM_FB-1:NUM_MC] == $past(pin_in, 2))
    else $error("pin feedback does not follow the pin");

  for (genvar k = 0; k < NUM_MC; k++) begin : g_oe_chk
    oe_off_a: assert property (@(posedge clock) disable iff (!rstn)
      mc_oe_src[k] == oe_always_off |=> pin_oe_n[k])
      else $error("forced-off output is driving");

    oe_on_a: assert property (@(posedge clock) disable iff (!rstn)
      mc_oe_src[k] == oe_always_on && !float_enable |=> !pin_oe_n[k])
      else $error("forced-on output is not driving");
  end

endmodule

//--- bench/pin_pad_model.sv
// board-side pad model: resolves each pin from the macrocell driver and a board driver
module pin_pad_model (
  input  wire logic [0:0]                clock,
  input  wire logic [cpld_pkg::NUM_MC-1:0] pin_out,
  input  wire logic [cpld_pkg::NUM_MC-1:0] pin_oe_n,
  input  wire logic [cpld_pkg::NUM_MC-1:0] board_level,
  input  wire logic [cpld_pkg::NUM_MC-1:0] board_drive,
  output logic      [cpld_pkg::NUM_MC-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpld_pkg::*;
  // starts defined so a floating pin never reads unknown into the pin feedback
  logic [NUM_MC-1:0] last_reg = '0;
  always @(posedge clock) begin
    last_reg <= pin_in;
  end
  // no pulls on the pads: an undriven pin shows its inverse last level so it never looks right
  always_comb begin
    for (int k = 0; k < NUM_MC; k++) begin
      if (!pin_oe_n[k]) begin
        pin_in[k] = pin_out[k];
      end else if (board_drive[k]) begin
        pin_in[k] = board_level[k];
      end else begin
        pin_in[k] = ~last_reg[k];
      end
    end
  end
endmodule

//--- bench/cpld_logic_block_tb.sv
// self-checking bench for one logic block with pad model and queued expectations
module cpld_logic_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpld_pkg::*;
  typedef struct {
    int          due;
    logic [31:0] val;
    logic [31:0] mask;
  } note_t;
  logic                                 clock, rstn, gfloat_n, float_enable;
  logic [NUM_GCLK-1:0]                  gclk, gclk_falling;
  logic [NUM_INPUTS-1:0]                gia;
  logic [NUM_FB-1:0]                    feedback_out;
  logic [NUM_MC-1:0]                    pin_in, pin_out, pin_oe_n, pr_en, b_lvl, b_drv, qm;
  logic [NUM_PAL-1:0][NUM_INPUTS-1:0]   pal_t, pal_c;
  logic [PLA_TERMS-1:0][NUM_INPUTS-1:0] pla_t, pla_c;
  logic [NUM_MC-1:0][PLA_TERMS-1:0]     or_m;
  logic [NUM_CT-1:0][NUM_INPUTS-1:0]    ct_t, ct_c;
  logic [NUM_CT-1:0]                    ct_sum;
  logic [3:1]                           gint;
  logic [3:1][3:0]                      geq;
  mc_mode_t                             mode [NUM_MC];
  clk_src_t                             csrc [NUM_MC];
  oe_src_t                              oe [NUM_MC];
  note_t                                exp_q [3][$];
  string                                nm [3] = '{"pin_out", "pin_oe_n", "feedback_out"};
  int                                   cyc, num_errors, n_compared;

  cpld_logic_block i_cpld_logic_block (
    .clock(clock), .rstn(rstn), .global_clock_zero(gclk[0]), .global_clock_one(gclk[1]),
    .global_clock_two(gclk[2]), .global_clock_three(gclk[3]),
    .global_output_float_n(gfloat_n), .float_enable(float_enable),
    .global_interconnect_array(gia), .feedback_out(feedback_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pal_true_mask(pal_t), .pal_comp_mask(pal_c),
    .pla_true_mask(pla_t), .pla_comp_mask(pla_c), .pla_or_mask(or_m),
    .ct_true_mask(ct_t), .ct_comp_mask(ct_c), .ct_sum_mode(ct_sum), .mc_mode(mode),
    .mc_clk_src(csrc), .mc_oe_src(oe), .mc_pr_enable(pr_en), .gclk_falling(gclk_falling),
    .gclk_internal(gint), .gclk_eq_mc(geq)
  );
  pin_pad_model i_pin_pad_model (
    .clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_level(b_lvl),
    .board_drive(b_drv), .pin_in(pin_in)
  );

  function automatic logic [15:0] comb_exp(logic [35:0] g);
    comb_exp = g[15:0];
    comb_exp[1:0] |= {2{g[35]}};
    comb_exp[2] |= g[34] & ~g[33];
    comb_exp[3] |= g[32];
  endfunction
  function automatic logic [15:0] oe_exp(logic [35:0] g);
    logic [5:0] ct;
    ct = {g[21] & g[22], g[20], g[25] & ~g[26], g[24] | g[27], g[29], g[28]};
    for (int k = 0; k < 16; k++) begin
      oe_exp[k] = (k % 6 == 4) ? 1'b0 : (k % 6 == 5) ? 1'b1 : ~ct[2 + k % 6];
    end
  endfunction
  task automatic note(input int s, input int lat, input logic [31:0] v, input logic [31:0] m);
    exp_q[s].push_back('{cyc + lat, v & m, m});
  endtask
  task automatic comb_step(input logic fl);
    @(negedge clock);
    gia = 36'({$urandom(), $urandom()});
    gia[29:28] = 2'b00;
    note(0, 1, 32'(comb_exp(gia)), 32'hffff);
    note(1, 1, 32'(fl ? 16'hffff : oe_exp(gia)), 32'hffff);
  endtask
  task automatic upd(input int s);
    for (int k = 0; k < NUM_MC; k++) begin
      if (csrc[k] == s) begin
        qm[k] = (mode[k] == mode_d) ? gia[k] : qm[k] ^ gia[k];
      end
    end
  endtask
  // global clock two driven by macrocell zero, which itself follows clock zero
  task automatic int_step(input logic fl);
    logic act;
    @(negedge clock);
    gia[15:0] = 16'($urandom());
    if (fl) begin
      gint[2] = 1'b1;
      act = qm[0] & ~gclk[2];
    end else begin
      gclk[0] = ~gclk[0];
      act = gclk[0] & ~qm[0] & gia[0];
      if (gclk[0]) begin
        upd(0);
      end
      note(0, 3, 32'(qm), 32'hffff);
    end
    if (act) begin
      upd(2);
    end
    note(0, fl ? 1 : 4, 32'(qm), 32'hffff);
    repeat (5) @(negedge clock);
  endtask
  task automatic clk_step();
    int   s;
    logic act;
    s = $urandom_range(5);
    @(negedge clock);
    gia[15:0] = 16'($urandom());
    if (s < 4) begin
      gclk[s] = ~gclk[s];
      act = gclk[s] ^ gclk_falling[s];
    end else begin
      gia[20 + s] = ~gia[20 + s];
      act = gia[20 + s];
    end
    if (act) begin
      upd(s);
    end
    note(0, (s < 4) ? 3 : 1, 32'(qm), 32'hffff);
    note(1, 1, 32'h0, 32'hffff);
    repeat (4) @(negedge clock);
  endtask
  task automatic finish_test();
    num_errors += exp_q[0].size() + exp_q[1].size() + exp_q[2].size();
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(negedge clock) begin
    for (int s = 0; s < 3; s++) begin
      while (exp_q[s].size() > 0 && exp_q[s][0].due <= cyc) begin
        note_t       n;
        logic [31:0] seen;
        n = exp_q[s].pop_front();
        seen = (s == 0) ? 32'(pin_out) : (s == 1) ? 32'(pin_oe_n) : feedback_out;
        n_compared++;
        if ((seen & n.mask) !== n.val) begin
          num_errors++;
          $display("unexpected %s: expected %h seen %h", nm[s], n.val, seen & n.mask);
        end
      end
    end
  end
  // the run is about 450 cycles; the ceiling leaves ample room
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    void'($urandom(83935));
    {rstn, gfloat_n, float_enable, gclk, gclk_falling} = {3'b010, 4'h0, 4'ha};
    {gia, b_lvl, b_drv, qm, pr_en, or_m, gint, geq} = '0;
    {cyc, num_errors, n_compared} = '0;
    for (int p = 0; p < NUM_PAL; p++) begin
      pal_t[p] = 36'h1;
      pal_c[p] = 36'h1;
      if (p < PLA_TERMS) begin
        pla_t[p] = 36'h1;
        pla_c[p] = 36'h1;
      end
    end
    // unused terms read x and not x, since an empty product would be true
    for (int k = 0; k < NUM_MC; k++) begin
      pal_t[5 * k] = 36'h1 << k;
      pal_c[5 * k] = 36'h0;
      mode[k] = mode_comb;
      csrc[k] = clk_src_t'(k % 6);
      oe[k] = oe_src_t'(k % 6);
    end
    {pal_t[16], pal_c[16]} = {36'h1_0000_0000, 36'h0};
    {pla_t[0], pla_c[0], pla_t[1], pla_c[1]} = {36'h8_0000_0000, 36'h0, 36'h4_0000_0000,
                                                36'h2_0000_0000};
    {or_m[0], or_m[1], or_m[2]} = {32'h1, 32'h1, 32'h2};
    ct_t = {36'h60_0000, 36'h10_0000, 36'h200_0000, 36'h900_0000, 36'h2000_0000, 36'h1000_0000};
    ct_c = {36'h0, 36'h0, 36'h400_0000, 36'h0, 36'h0, 36'h0};
    ct_sum = 6'b010111;
    repeat (10) @(negedge clock);
    note(0, 1, 32'h0, 32'hffff);
    note(1, 1, 32'hffff, 32'hffff);
    note(2, 1, 32'h0, 32'hffff_ffff);
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (40) comb_step(1'b0);
    gfloat_n = 1'b0;
    repeat (6) comb_step(1'b0);
    @(negedge clock);
    float_enable = 1'b1;
    repeat (4) @(negedge clock);
    repeat (6) comb_step(1'b1);
    gfloat_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int k = 0; k < NUM_MC; k++) begin
      oe[k] = oe_always_off;
    end
    comb_step(1'b1);
    repeat (30) begin
      comb_step(1'b1);
      b_drv = 16'($urandom());
      b_lvl = 16'($urandom());
      note(2, 1, 32'(comb_exp(gia)), 32'hffff);
      note(2, 2, {b_lvl, 16'h0}, {b_drv, 16'h0});
    end
    @(negedge clock);
    gia = '0;
    note(0, 1, 32'h0, 32'hffff);
    @(negedge clock);
    for (int k = 0; k < NUM_MC; k++) begin
      mode[k] = (k < 8) ? mode_d : mode_t;
      oe[k] = oe_always_on;
    end
    repeat (60) clk_step();
    int_step(1'b1);
    repeat (6) int_step(1'b0);
    // zero data keeps the toggle cells still while macrocells zero to seven are preset and reset
    gia[15:0] = '0;
    pr_en = 16'h00ff;
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      gia[29:28] = 2'(8'h4d >> (2 * i));
      qm[7:0] = gia[29] ? 8'h00 : gia[28] ? 8'hff : qm[7:0];
      note(0, 1, 32'(qm), 32'hffff);
      repeat (2) @(negedge clock);
    end
    @(negedge clock);
    gia[28] = 1'b0;
    rstn = 1'b0;
    note(0, 1, 32'h0, 32'hffff);
    note(1, 1, 32'hffff, 32'hffff);
    repeat (3) @(negedge clock);
    finish_test();
  end
endmodule
